// [bench/cac_change_status_properties.sv]
// port assertions for the alarm change latch block
// assumes one clock domain and a bind onto cac_change_status
`timescale 1ns/1ps
module cac_change_status_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] fifoLimitAlarm,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] receiveLockLoss,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] receiveSignalLoss,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] transmitDriveFault,
    input wire logic [cac_pkg::NUM_CHANNELS*cac_pkg::NUM_EVENTS-1:0] changeIntEnable,
    input wire logic regRead,
    input wire logic [cac_pkg::ADDR_W-1:0] regAddr,
    input wire logic [cac_pkg::DATA_W-1:0] regRdata,
    input wire logic regRdValid,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] channelIrq,
    input wire logic anyIrq
);
    import cac_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_valid; regRead |=> regRdValid && anyIrq == |channelIrq; endproperty
    a_valid: assert property (p_valid) else $error("read not answered");
    property p_upper; regRdValid |-> regRdata[7:4] == 4'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    // $past(rstn) guard: level history restarts at zero on reset
    property p_fifo; $past(rstn) && $changed(fifoLimitAlarm[0]) && changeIntEnable[3] ##1 changeIntEnable[3]
        |=> channelIrq[0]; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo change lost");
    property p_lock; $past(rstn) && $changed(receiveLockLoss[1]) && changeIntEnable[6] ##1 changeIntEnable[6]
        |=> channelIrq[1]; endproperty
    a_lock: assert property (p_lock) else $error("lock change lost");
    property p_signal; $past(rstn) && $changed(receiveSignalLoss[2]) && changeIntEnable[9] ##1 changeIntEnable[9]
        |=> channelIrq[2]; endproperty
    a_signal: assert property (p_signal) else $error("signal change lost");
    property p_drive; $past(rstn) && $changed(transmitDriveFault[0]) && changeIntEnable[0] ##1 changeIntEnable[0]
        |=> channelIrq[0]; endproperty
    a_drive: assert property (p_drive) else $error("drive change lost");
    property p_clear; regRead && regAddr == 8'h02 && $past(rstn)
        && $stable({fifoLimitAlarm[0], receiveLockLoss[0], receiveSignalLoss[0], transmitDriveFault[0]})
        ##1 $stable({fifoLimitAlarm[0], receiveLockLoss[0], receiveSignalLoss[0], transmitDriveFault[0]})
        ##1 regRead && regAddr == 8'h02 |=> regRdata == 8'h00; endproperty
    a_clear: assert property (p_clear) else $error("read did not clear");
    property p_level; regRead && regAddr == 8'h03 |=> regRdata == {4'h0, $past(fifoLimitAlarm[0]),
        $past(receiveLockLoss[0]), $past(receiveSignalLoss[0]), $past(transmitDriveFault[0])}; endproperty
    a_level: assert property (p_level) else $error("level view wrong");
endmodule
bind cac_change_status cac_change_status_properties u_props (.clk, .rstn, .fifoLimitAlarm, .receiveLockLoss,
    .receiveSignalLoss, .transmitDriveFault, .changeIntEnable, .regRead, .regAddr, .regRdata, .regRdValid,
    .channelIrq, .anyIrq);

// [bench/cac_host_model.sv]
// host model issuing register reads on the strobe port
// assumes the answer is registered on the taking edge and is ready 1 ns after it
`timescale 1ns/1ps
module cac_host_model (
    input wire logic clk,
    output logic regRead,
    output logic [7:0] regAddr,
    input wire logic regRdValid,
    input wire logic [7:0] regRdata
);
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        // released address flips so a stale value cannot pass
        regAddr <= ~a;
        #1;
        ok = regRdValid;
        d = regRdata;
    endtask
endmodule

// [bench/tb_cac_change_status.sv]
// testbench for the alarm change latch block
// assumes a 100 MHz clock and synchronous active-low reset
`timescale 1ns/1ps
module tb_cac_change_status;
    import cac_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] lvl [3];
    logic [11:0] en = 12'hfff;
    logic regRead, regRdValid, ok, anyIrq;
    logic [7:0] regAddr, regRdata, d;
    logic [2:0] channelIrq;
    int num_errors = 0;
    int checks = 0;
    always #5 clk = ~clk;
    cac_change_status u_dut (.clk, .rstn, .fifoLimitAlarm({lvl[2][3], lvl[1][3], lvl[0][3]}),
        .receiveLockLoss({lvl[2][2], lvl[1][2], lvl[0][2]}), .receiveSignalLoss({lvl[2][1], lvl[1][1], lvl[0][1]}),
        .transmitDriveFault({lvl[2][0], lvl[1][0], lvl[0][0]}), .changeIntEnable(en), .regRead, .regAddr,
        .regRdata, .regRdValid, .channelIrq, .anyIrq);
    cac_host_model u_host (.clk, .regRead, .regAddr, .regRdValid, .regRdata);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask
    // fixed latency read; a missing answer counts as a mismatch
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d, ok);
        chk({7'h0, ok}, 8'h01);
        chk(d, e);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        lvl = '{4'h0, 4'h0, 4'h0};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            rd(8'h02 + 8'(8 * c), 8'h00);
        end
        rd(8'h01, 8'h00);
        for (int c = 0; c < 3; c++) begin
            for (int b = 0; b < 4; b++) begin
                @(posedge clk);
                lvl[c][b] <= 1'b1;
                repeat (2) @(posedge clk);
                #1 chk({4'h0, anyIrq, channelIrq}, 8'h08 | (8'h01 << c));
                rd(8'h02 + 8'(8 * c), 8'h01 << b);
                rd(8'h02 + 8'(8 * c), 8'h00);
                rd(8'h03 + 8'(8 * c), 8'h01 << b);
                @(posedge clk);
                lvl[c][b] <= 1'b0;
                rd(8'h02 + 8'(8 * c), 8'h01 << b);
            end
        end
        @(posedge clk);
        en <= 12'h000;
        lvl[0][3] <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({4'h0, anyIrq, channelIrq}, 8'h00);
        end_of_test;
    end
endmodule

// [rtl/cac_chan_if.sv]
// per-channel bundle between the register front and one change latch
// assumes a single clock domain
`timescale 1ns/1ps
interface cac_chan_if;
    import cac_pkg::*;
    cac_event_t condLevel;
    logic readClear;
    cac_event_t changeLatched;
    modport latch (input condLevel, input readClear, output changeLatched);
    modport front (output condLevel, output readClear, input changeLatched);
endinterface

// [rtl/cac_chan_latch.sv]
// one channel: detects both edges of each condition and holds them until read
// assumes condition levels are already synchronous to clk
`timescale 1ns/1ps
module cac_chan_latch (
    input wire logic clk,
    input wire logic rstn,
    cac_chan_if.latch chan
);
    import cac_pkg::*;

    cac_event_t prevLevel_reg;
    cac_event_t latched_reg;
    cac_event_t latched_next;
    cac_event_t changed;

    // declare and clear both count as a change
    assign changed = chan.condLevel ^ prevLevel_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prevLevel_reg <= EVENT_RESET;
        end else begin
            prevLevel_reg <= chan.condLevel;
        end
    end

    // set beats clear so an event landing on the read edge survives to the next read
    always_comb begin
        latched_next = latched_reg;
        if (chan.readClear) begin
            latched_next = EVENT_RESET;
        end
        latched_next = latched_next | changed;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            latched_reg <= EVENT_RESET;
        end else begin
            latched_reg <= latched_next;
        end
    end

    assign chan.changeLatched = latched_reg;
endmodule

// [rtl/cac_change_status.sv]
// register front for the three-channel alarm change latches and alarm levels
// assumes a serial host port upstream turns each register read into a one-cycle strobe
// Overview of operation
// - three change-latch copies, one per channel, at 0x02, 0x0A and 0x12
// - bit 3 flags a fifo limit alarm change since last read; read clears
// - bit 2 flags a receive lock loss change since last read; read clears
// - bit 1 latches receive signal loss changes; cleared by read and reset
// - live fifo limit alarm level readable at alarm status bit 3
// - live receive lock loss level readable at alarm status bit 2
// - bit 0 latches transmit drive fault changes since last read; read clears
// - change event raised on both declare and clear of a condition
// - a change raises an interrupt only if its enable bit is 1
`timescale 1ns/1ps
module cac_change_status (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] fifoLimitAlarm,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] receiveLockLoss,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] receiveSignalLoss,
    input wire logic [cac_pkg::NUM_CHANNELS-1:0] transmitDriveFault,
    input wire logic [cac_pkg::NUM_CHANNELS*cac_pkg::NUM_EVENTS-1:0] changeIntEnable,
    input wire logic regRead,
    input wire logic [cac_pkg::ADDR_W-1:0] regAddr,
    output logic [cac_pkg::DATA_W-1:0] regRdata,
    output logic regRdValid,
    output logic [cac_pkg::NUM_CHANNELS-1:0] channelIrq,
    output logic anyIrq
);
    import cac_pkg::*;

    // one-hot channel match for a register family at base + n * stride
    function automatic logic [NUM_CHANNELS-1:0] channelHit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] base
    );
        logic [NUM_CHANNELS-1:0] hit;
        logic [7:0] slot;
        hit = '0;
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            slot = 8'(base + 8'(n) * CHANNEL_STRIDE);
            hit[n] = (addr == slot);
        end
        return hit;
    endfunction

    // gather the four conditions of one channel into field order
    function automatic cac_event_t packEvents(
        input logic fifoLimit,
        input logic lockLoss,
        input logic signalLoss,
        input logic driveFault
    );
        cac_event_t ev;
        ev = EVENT_RESET;
        ev[BIT_FIFO_LIMIT_ALARM] = fifoLimit;
        ev[BIT_RECEIVE_LOCK_LOSS] = lockLoss;
        ev[BIT_RECEIVE_SIGNAL_LOSS] = signalLoss;
        ev[BIT_TRANSMIT_DRIVE_FAULT] = driveFault;
        return ev;
    endfunction

    cac_chan_if chanBus [NUM_CHANNELS] ();

    logic [NUM_CHANNELS-1:0] changeHit;
    logic [NUM_CHANNELS-1:0] levelHit;
    cac_event_t condLevel [NUM_CHANNELS];
    cac_event_t changeLatched [NUM_CHANNELS];
    logic [DATA_W-1:0] readData_next;
    logic [NUM_CHANNELS-1:0] channelIrq_next;

    assign changeHit = channelHit(regAddr, CHANGE_LATCH_BASE);
    assign levelHit = channelHit(regAddr, ALARM_LEVEL_BASE);

    for (genvar n = 0; n < NUM_CHANNELS; n++) begin : gChan
        assign condLevel[n] = packEvents(fifoLimitAlarm[n], receiveLockLoss[n],
                                         receiveSignalLoss[n], transmitDriveFault[n]);
        assign chanBus[n].condLevel = condLevel[n];
        // clear only on a read that really hits this channel's copy
        assign chanBus[n].readClear = regRead & changeHit[n];
        assign changeLatched[n] = chanBus[n].changeLatched;

        cac_chan_latch uLatch (
            .clk(clk),
            .rstn(rstn),
            .chan(chanBus[n])
        );
    end

    // read mux; the value returned is the latch before this read clears it
    always_comb begin
        readData_next = READ_UNMAPPED;
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            if (changeHit[n]) begin
                // upper nibble is padded with zeros, so it reads zero
                readData_next = {{(DATA_W-NUM_EVENTS){1'b0}}, changeLatched[n]};
            end
            if (levelHit[n]) begin
                // only the four levels this block sees; other status bits read zero here
                readData_next = {{(DATA_W-NUM_EVENTS){1'b0}}, condLevel[n]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdata <= CHANGE_LATCH_RESET;
        end else if (regRead) begin
            regRdata <= readData_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
        end
    end

    // per-channel request: latched changes gated by their enables
    always_comb begin
        channelIrq_next = '0;
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            channelIrq_next[n] = |(changeLatched[n] & changeIntEnable[n*NUM_EVENTS +: NUM_EVENTS]);
        end
    end

    // one cycle of lag keeps the outputs glitch free
    always_ff @(posedge clk) begin
        if (!rstn) begin
            channelIrq <= '0;
        end else begin
            channelIrq <= channelIrq_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            anyIrq <= 1'b0;
        end else begin
            anyIrq <= |channelIrq_next;
        end
    end
endmodule

// [rtl/cac_pkg.sv]
// constants for the per-channel alarm change latch block
// assumes an 8-bit register address space decoded upstream of this block
package cac_pkg;
    localparam int NUM_CHANNELS = 3;
    localparam int NUM_EVENTS = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // channel n sits at base + n * stride
    localparam logic [7:0] CHANNEL_STRIDE = 8'h08;
    localparam logic [7:0] CHANGE_LATCH_BASE = 8'h02;
    localparam logic [7:0] ALARM_LEVEL_BASE = 8'h03;
    // field positions, shared by the change latch and the alarm level view
    localparam int BIT_FIFO_LIMIT_ALARM = 3;
    localparam int BIT_RECEIVE_LOCK_LOSS = 2;
    localparam int BIT_RECEIVE_SIGNAL_LOSS = 1;
    localparam int BIT_TRANSMIT_DRIVE_FAULT = 0;
    localparam logic [DATA_W-1:0] CHANGE_LATCH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
    localparam logic [NUM_EVENTS-1:0] EVENT_RESET = 4'h0;
    typedef logic [NUM_EVENTS-1:0] cac_event_t;
endpackage
